// ==== inc/pfr_defines.svh ====
// Register offsets, field positions, reset values and codes of the PWM fault and prescaler block.
`ifndef PFR_DEFINES_SVH
`define PFR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PFR_OFS_CONTROL    8'h00
`define PFR_OFS_FAULT_CTL  8'h04
`define PFR_OFS_PRESCALE   8'h08
`define PFR_OFS_TRIG_CTL   8'h0C
`define PFR_OFS_IRQ_STAT   8'h10
`define PFR_OFS_IRQ_MASK   8'h14
`define PFR_OFS_STATUS     8'h18
`define PFR_OFS_PULLDOWN   8'h1C
`define PFR_OFS_PERIOD     8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PFR_CTL_EN_BIT     0
`define PFR_FMODE_MSB      1
`define PFR_FMODE_LSB      0
`define PFR_PRE_MSB        2
`define PFR_PRE_LSB        0
`define PFR_TDIV_MSB       15
`define PFR_TDIV_LSB       12
`define PFR_TSTRT_MSB      5
`define PFR_TSTRT_LSB      0
`define PFR_IRQ_FAULT_BIT  0
`define PFR_IRQ_TRIG_BIT   1
`define PFR_IRQ_SEQ_BIT    2
`define PFR_ST_LATCH_BIT   0
`define PFR_ST_PIN_BIT     1
`define PFR_ST_SAFE_BIT    2
`define PFR_ST_EN_BIT      3

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define PFR_FMODE_LATCHED  2'h0
`define PFR_FMODE_CYCLE    2'h1
`define PFR_FMODE_OFF      2'h3
`define PFR_PRE_RST        3'h0
`define PFR_PRE_RESERVED   3'h7
`define PFR_PERIOD_RST     16'h00FF
`define PFR_IRQ_W          3

`endif

// ==== inc/pfr_pkg.sv ====
// Types shared by the PWM fault and prescaler block.
package pfr_pkg;

	typedef enum logic [1:0] {
		TRG_IDLE,
		TRG_DELAY,
		TRG_RUN
	} pfr_trig_state_type;

	typedef logic [2:0] pfr_div_sel_type;

endpackage

// ==== rtl/pfr_prescaler.sv ====
// Input clock prescaler: one-cycle enable pulse at clk divided by 1 to 64.
`timescale 1ns/1ps
`include "pfr_defines.svh"

module pfr_prescaler
	import pfr_pkg::*;
#(
	parameter int CNT_W = 6
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            run,
	input  wire pfr_div_sel_type sel,
	output logic                 tick
);

	initial begin
		if (CNT_W < 6) begin
			$error("pfr_prescaler: CNT_W must be at least 6");
		end
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] mask;
	pfr_div_sel_type  sel_q;
	wire              sel_chg;
	wire              wrap;

	// The reserved code is treated as the slowest divider.
	assign mask    = (sel == `PFR_PRE_RESERVED) ? CNT_W'((1 << 6) - 1) : CNT_W'((1 << sel) - 1);
	assign sel_chg = (sel != sel_q);
	assign wrap    = ((cnt_q & mask) == mask);
	assign tick    = run && !sel_chg && wrap;

	// A divider change restarts the count; a change while running still
	// gives an irregular first period.
	always_ff @(posedge clk) begin
		sel_q <= rst ? `PFR_PRE_RST : sel;
		if (rst || !run || sel_chg || wrap) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

endmodule

// ==== rtl/pfr_top.sv ====
// PWM fault latch, input clock prescaler and ADC trigger postscaler with an APB register file.
`timescale 1ns/1ps
`include "pfr_defines.svh"

module pfr_top
	import pfr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              safety_fault_input,
	output logic                   fault_input_owned,
	output logic                   fault_pulldown_en,
	output logic                   pwm_safe_state,
	output logic                   pwm_module_enable,
	output logic                   adc_trigger,
	output logic                   irq
);

	initial begin
		if (ADDR_W < 6) begin
			$error("pfr_top: ADDR_W must be at least 6");
		end
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic        ack_q;
	logic [31:0] rdata_q;
	wire         access = psel && penable;
	wire         wr     = access && pwrite && ack_q;
	wire [7:0]   ofs    = 8'(paddr);
	wire         hi_zero = (paddr >> 8) == '0;
	wire         sel_ctl  = hi_zero && ofs == `PFR_OFS_CONTROL;
	wire         sel_flt  = hi_zero && ofs == `PFR_OFS_FAULT_CTL;
	wire         sel_pre  = hi_zero && ofs == `PFR_OFS_PRESCALE;
	wire         sel_trg  = hi_zero && ofs == `PFR_OFS_TRIG_CTL;
	wire         sel_ist  = hi_zero && ofs == `PFR_OFS_IRQ_STAT;
	wire         sel_imk  = hi_zero && ofs == `PFR_OFS_IRQ_MASK;
	wire         sel_sts  = hi_zero && ofs == `PFR_OFS_STATUS;
	wire         sel_pd   = hi_zero && ofs == `PFR_OFS_PULLDOWN;
	wire         sel_per  = hi_zero && ofs == `PFR_OFS_PERIOD;
	wire         hit = sel_ctl | sel_flt | sel_pre | sel_trg | sel_ist | sel_imk | sel_sts | sel_pd | sel_per;

	// One wait state lets read data come from a flop.
	assign pready  = access && ack_q;
	assign pslverr = access && ack_q && !hit;
	assign prdata  = rdata_q;

	always_ff @(posedge clk) begin
		ack_q <= rst ? 1'b0 : (access && !ack_q);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic                  enable_q;
	logic [1:0]            fmode_q;
	pfr_div_sel_type       pre_q;
	logic [3:0]            tdiv_q;
	logic [5:0]            tstrt_q;
	logic [`PFR_IRQ_W-1:0] ist_q;
	logic [`PFR_IRQ_W-1:0] imk_q;
	logic                  pd_q;
	logic [15:0]           period_q;
	logic                  latch_q;
	logic                  safe_q;
	logic                  trig_q;

	wire en_req   = wr && sel_ctl && pwdata[`PFR_CTL_EN_BIT];
	wire en_block = en_req && latch_q;
	wire clr_req  = wr && sel_sts && pwdata[`PFR_ST_LATCH_BIT];
	wire latch_set = (fmode_q == `PFR_FMODE_LATCHED) && safety_fault_input;
	wire latch_d   = latch_set || (latch_q && !clr_req);
	wire fault_active = ((fmode_q == `PFR_FMODE_LATCHED) && latch_q) ||
	                    ((fmode_q == `PFR_FMODE_CYCLE) && safety_fault_input);

	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q <= 1'b0;
			fmode_q  <= `PFR_FMODE_LATCHED;
			pre_q    <= `PFR_PRE_RST;
			tdiv_q   <= '0;
			tstrt_q  <= '0;
			imk_q    <= '0;
			pd_q     <= 1'b0;
			period_q <= `PFR_PERIOD_RST;
		end else if (wr) begin
			if (sel_ctl) begin
				// An enable while the fault is still latched is refused.
				enable_q <= pwdata[`PFR_CTL_EN_BIT] && !latch_q;
			end
			if (sel_flt) begin
				fmode_q <= pwdata[`PFR_FMODE_MSB:`PFR_FMODE_LSB];
			end
			if (sel_pre) begin
				pre_q <= pwdata[`PFR_PRE_MSB:`PFR_PRE_LSB];
			end
			if (sel_trg) begin
				tdiv_q  <= pwdata[`PFR_TDIV_MSB:`PFR_TDIV_LSB];
				tstrt_q <= pwdata[`PFR_TSTRT_MSB:`PFR_TSTRT_LSB];
			end
			if (sel_imk) begin
				imk_q <= pwdata[`PFR_IRQ_W-1:0];
			end
			if (sel_pd) begin
				pd_q <= pwdata[0];
			end
			if (sel_per) begin
				period_q <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Fault latch and safe state
	// ----------------------------------------------------------------
	// The latch powers up set, so outputs start safe. A clear written in latched mode while
	// the pin is still high loses to the set and has no effect.
	always_ff @(posedge clk) begin
		latch_q <= rst ? 1'b1 : latch_d;
		safe_q  <= rst ? 1'b1 : fault_active;
	end

	// The fault pin stays with this block during reset and while the fault mode is not off.
	assign fault_input_owned = rst || (fmode_q != `PFR_FMODE_OFF);
	assign fault_pulldown_en = pd_q;
	assign pwm_safe_state    = safe_q;
	assign pwm_module_enable = enable_q;

	// ----------------------------------------------------------------
	// Prescaler and PWM cycle counter
	// ----------------------------------------------------------------
	logic        tick;
	logic [15:0] per_cnt_q;
	wire         cycle_end = tick && (per_cnt_q == period_q);

	// The divider is not guarded against changes while running.
	pfr_prescaler #(
		.CNT_W (6)
	) u_pre (
		.clk  (clk),
		.rst  (rst),
		.run  (enable_q),
		.sel  (pre_q),
		.tick (tick)
	);

	always_ff @(posedge clk) begin
		if (rst || !enable_q || cycle_end) begin
			per_cnt_q <= '0;
		end else if (tick) begin
			per_cnt_q <= per_cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Trigger start delay and postscaler
	// ----------------------------------------------------------------
	pfr_trig_state_type st_q;
	pfr_trig_state_type st_d;
	logic [5:0]         dly_q;
	logic [3:0]         post_q;
	logic               en_prev_q;
	wire                en_rise = enable_q && !en_prev_q;
	wire                trig_event = cycle_end &&
	                    (st_q == TRG_RUN || (st_q == TRG_DELAY && dly_q == 6'h00));
	wire                trig_fire = trig_event && (post_q == tdiv_q);

	always_comb begin
		st_d = st_q;
		case (st_q)
			TRG_IDLE: begin
				if (en_rise) begin
					st_d = TRG_DELAY;
				end
			end
			TRG_DELAY: begin
				if (!enable_q) begin
					st_d = TRG_IDLE;
				end else if (trig_event) begin
					st_d = TRG_RUN;
				end
			end
			TRG_RUN: begin
				if (!enable_q) begin
					st_d = TRG_IDLE;
				end
			end
			default: begin
				st_d = TRG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q      <= TRG_IDLE;
			dly_q     <= '0;
			post_q    <= '0;
			en_prev_q <= 1'b0;
			trig_q    <= 1'b0;
		end else begin
			st_q      <= st_d;
			en_prev_q <= enable_q;
			trig_q    <= trig_fire;
			if (en_rise) begin
				dly_q <= tstrt_q;
			end else if (st_q == TRG_DELAY && cycle_end && dly_q != 6'h00) begin
				dly_q <= dly_q - 6'h01;
			end
			if (!enable_q || trig_fire) begin
				post_q <= '0;
			end else if (trig_event) begin
				post_q <= post_q + 4'h1;
			end
		end
	end

	assign adc_trigger = trig_q;

	// ----------------------------------------------------------------
	// Interrupts and read data
	// ----------------------------------------------------------------
	wire [`PFR_IRQ_W-1:0] ev = {en_block, trig_fire, latch_set && !latch_q};
	wire [`PFR_IRQ_W-1:0] w1c = (wr && sel_ist) ? pwdata[`PFR_IRQ_W-1:0] : '0;

	always_ff @(posedge clk) begin
		ist_q <= rst ? '0 : (ev | (ist_q & ~w1c));
	end

	assign irq = |(ist_q & imk_q);

	wire [31:0] rd_sts = {28'h0000000, enable_q, safe_q, safety_fault_input, latch_q};
	wire [31:0] rd_mux =
		sel_ctl ? {31'h00000000, enable_q} :
		sel_flt ? {30'h00000000, fmode_q} :
		sel_pre ? {29'h00000000, pre_q} :
		sel_trg ? {16'h0000, tdiv_q, 6'h00, tstrt_q} :
		sel_ist ? {29'h00000000, ist_q} :
		sel_imk ? {29'h00000000, imk_q} :
		sel_sts ? rd_sts :
		sel_pd  ? {31'h00000000, pd_q} :
		sel_per ? {16'h0000, period_q} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (access && !ack_q && !pwrite) begin
			rdata_q <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking

	sequence s_wr_fault_mode;
		wr && sel_flt && safety_fault_input;
	endsequence

	property p_own_in_reset;
		rst |-> fault_input_owned;
	endproperty
	a_own_in_reset: assert property (p_own_in_reset) else $error("fault input released in reset");

	property p_reset_latched;
		$fell(rst) |-> (fmode_q == `PFR_FMODE_LATCHED) && latch_q && pwm_safe_state;
	endproperty
	a_reset_latched: assert property (p_reset_latched) else $error("not latched after reset");

	property p_enable_refused;
		disable iff (rst) en_block |=> !pwm_module_enable && ist_q[`PFR_IRQ_SEQ_BIT];
	endproperty
	a_enable_refused: assert property (p_enable_refused) else $error("enable taken with fault latched");

	property p_clear_needs_low;
		disable iff (rst) (clr_req && latch_set) |=> latch_q;
	endproperty
	a_clear_needs_low: assert property (p_clear_needs_low) else $error("latch cleared with pin high");

	property p_mode_any_time;
		disable iff (rst) s_wr_fault_mode |=> fmode_q == $past(pwdata[1:0]);
	endproperty
	a_mode_any_time: assert property (p_mode_any_time) else $error("mode write lost");

	property p_div_by_two;
		disable iff (rst) (tick && pre_q == 3'h1 && $stable(pre_q) && enable_q) ##1 (enable_q && pre_q == 3'h1)
			|-> !tick ##1 (tick || !enable_q || pre_q != 3'h1);
	endproperty
	a_div_by_two: assert property (p_div_by_two) else $error("divide by two spacing wrong");

	property p_pre_upper_zero;
		disable iff (rst) (pready && !pwrite && sel_pre) |-> prdata[31:3] == '0;
	endproperty
	a_pre_upper_zero: assert property (p_pre_upper_zero) else $error("prescale upper bits not zero");

	property p_postscale_fire;
		disable iff (rst) (trig_event && post_q == tdiv_q) |=> adc_trigger;
	endproperty
	a_postscale_fire: assert property (p_postscale_fire) else $error("postscaled trigger missing");

	property p_start_hold;
		disable iff (rst) (st_q == TRG_DELAY && dly_q != 6'h00) |=> !adc_trigger;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("trigger during start delay");

	property p_safe_follows_latch;
		disable iff (rst) (fmode_q == `PFR_FMODE_LATCHED && latch_q) |=> pwm_safe_state;
	endproperty
	a_safe_follows_latch: assert property (p_safe_follows_latch) else $error("outputs not safe");

endmodule

// ==== verification/tb_pwm_fault_reset_and_prescaler.sv ====
// Self-checking testbench of the PWM fault latch, prescaler and trigger postscaler block.
`timescale 1ns/1ps
`include "pfr_defines.svh"

module tb_pwm_fault_reset_and_prescaler;

	typedef struct {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} pfr_tb_row_type;

	localparam int NROWS = 19;

	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        safety_fault_input;
	logic        fault_input_owned;
	logic        fault_pulldown_en;
	logic        pwm_safe_state;
	logic        pwm_module_enable;
	logic        adc_trigger;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          err_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          n0;
	int          n;
	int          first;
	int          ps;

	pfr_tb_row_type rows [NROWS] = '{
		'{1'b0, `PFR_OFS_STATUS, 32'h0, 32'h7, 1'b0},
		'{1'b0, `PFR_OFS_FAULT_CTL, 32'h0, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_PRESCALE, 32'h0, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_PERIOD, 32'h0, 32'h000000FF, 1'b0},
		'{1'b0, `PFR_OFS_TRIG_CTL, 32'h0, 32'h0, 1'b0},
		'{1'b1, `PFR_OFS_PRESCALE, 32'hFFFFFFFF, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_PRESCALE, 32'h0, 32'h7, 1'b0},
		'{1'b1, `PFR_OFS_PRESCALE, 32'h5, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_PRESCALE, 32'h0, 32'h5, 1'b0},
		'{1'b1, `PFR_OFS_FAULT_CTL, 32'h1, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_FAULT_CTL, 32'h0, 32'h1, 1'b0},
		'{1'b1, `PFR_OFS_FAULT_CTL, 32'h0, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_FAULT_CTL, 32'h0, 32'h0, 1'b0},
		'{1'b1, `PFR_OFS_TRIG_CTL, 32'hFFFFFFFF, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_TRIG_CTL, 32'h0, 32'h0000F03F, 1'b0},
		'{1'b1, 8'h24, 32'h1, 32'h0, 1'b1},
		'{1'b0, 8'h24, 32'h0, 32'h0, 1'b1},
		'{1'b1, `PFR_OFS_IRQ_MASK, 32'h4, 32'h0, 1'b0},
		'{1'b0, `PFR_OFS_IRQ_MASK, 32'h0, 32'h4, 1'b0}
	};

	pfr_top #(.ADDR_W(8)) uut (
		.clk               (clk),
		.rst               (rst),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.safety_fault_input(safety_fault_input),
		.fault_input_owned (fault_input_owned),
		.fault_pulldown_en (fault_pulldown_en),
		.pwm_safe_state    (pwm_safe_state),
		.pwm_module_enable (pwm_module_enable),
		.adc_trigger       (adc_trigger),
		.irq               (irq)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task summarize;
		$display("Mismatches %0d, comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask

	task chkb(input string nm, input logic x, input logic g);
		comparisons++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, x, g);
		end
	endtask

	task chkn(input string nm, input int x, input int g);
		comparisons++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, x, g);
		end
	endtask

	// The request stands from the setup edge to the rising edge at which pready is seen high.
	// Read data and the error flag are taken at that same edge, and only then is the request released.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, rd, er);
		chk(nm, x, rd);
	endtask

	task wait_trig(output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (adc_trigger !== 1'b1 && c < 5000);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		safety_fault_input = 1'b1;
		repeat (11) @(posedge clk);
		@(negedge clk);
		chkb("owned_in_reset", 1'b1, fault_input_owned);
		chkb("safe_in_reset", 1'b1, pwm_safe_state);
		@(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < NROWS; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
			if (!rows[i].w)
				chk("reg_read", rows[i].x, rd);
			chkb("slverr", rows[i].e, er);
		end
		wr(`PFR_OFS_CONTROL, 32'h1);
		rdc("enable_refused", `PFR_OFS_CONTROL, 32'h0);
		chkb("enable_port", 1'b0, pwm_module_enable);
		chkb("irq_refused", 1'b1, irq);
		wr(`PFR_OFS_IRQ_STAT, 32'h4);
		@(negedge clk);
		chkb("irq_cleared", 1'b0, irq);
		wr(`PFR_OFS_STATUS, 32'h1);
		rdc("clear_pin_high", `PFR_OFS_STATUS, 32'h7);
		wr(`PFR_OFS_PULLDOWN, 32'h1);
		@(negedge clk);
		chkb("pulldown", 1'b1, fault_pulldown_en);
		@(posedge clk);
		safety_fault_input <= 1'b0;
		repeat (3) @(negedge clk);
		chkb("safe_until_clear", 1'b1, pwm_safe_state);
		wr(`PFR_OFS_STATUS, 32'h1);
		repeat (3) @(negedge clk);
		chkb("safe_released", 1'b0, pwm_safe_state);
		rdc("status_clear", `PFR_OFS_STATUS, 32'h0);
		wr(`PFR_OFS_CONTROL, 32'h1);
		@(negedge clk);
		chkb("enable_after_clear", 1'b1, pwm_module_enable);
		wr(`PFR_OFS_CONTROL, 32'h0);
		wr(`PFR_OFS_FAULT_CTL, 32'h3);
		@(negedge clk);
		chkb("owned_off", 1'b0, fault_input_owned);
		wr(`PFR_OFS_FAULT_CTL, 32'h0);
		@(negedge clk);
		chkb("owned_latched", 1'b1, fault_input_owned);
		// In cycle mode the safe state follows the pin and nothing is latched.
		wr(`PFR_OFS_FAULT_CTL, 32'h1);
		safety_fault_input <= 1'b1;
		repeat (3) @(negedge clk);
		chkb("cycle_mode_safe", 1'b1, pwm_safe_state);
		@(posedge clk);
		safety_fault_input <= 1'b0;
		repeat (3) @(negedge clk);
		chkb("cycle_mode_release", 1'b0, pwm_safe_state);
		wr(`PFR_OFS_FAULT_CTL, 32'h0);
		// A PWM cycle is two prescaler ticks, so each trigger spacing is twice the divider.
		wr(`PFR_OFS_PERIOD, 32'h1);
		wr(`PFR_OFS_TRIG_CTL, 32'h0);
		for (int c = 0; c < 8; c++) begin
			wr(`PFR_OFS_PRESCALE, c);
			wr(`PFR_OFS_CONTROL, 32'h1);
			wait_trig(n0);
			wait_trig(n);
			chkn("divider_interval", 2 << ((c == 7) ? 6 : c), n);
			wr(`PFR_OFS_CONTROL, 32'h0);
			if (c == 0)
				first = n0;
		end
		wr(`PFR_OFS_PRESCALE, 32'h0);
		wr(`PFR_OFS_TRIG_CTL, 32'h3F);
		wr(`PFR_OFS_CONTROL, 32'h1);
		wait_trig(n0);
		chkn("start_delay", 126, n0 - first);
		wr(`PFR_OFS_CONTROL, 32'h0);
		for (int k = 0; k < 2; k++) begin
			ps = k ? 15 : 3;
			wr(`PFR_OFS_TRIG_CTL, ps << 12);
			wr(`PFR_OFS_CONTROL, 32'h1);
			wait_trig(n0);
			wait_trig(n);
			chkn("postscale_interval", (ps + 1) * 2, n);
			wr(`PFR_OFS_CONTROL, 32'h0);
		end
		wr(`PFR_OFS_PRESCALE, 32'h6);
		wr(`PFR_OFS_FAULT_CTL, 32'h3);
		@(posedge clk);
		rst <= 1'b1;
		@(negedge clk);
		chkb("owned_second_reset", 1'b1, fault_input_owned);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chkb("safe_second_reset", 1'b1, pwm_safe_state);
		@(posedge clk);
		rst <= 1'b0;
		rdc("prescale_second_reset", `PFR_OFS_PRESCALE, 32'h0);
		rdc("status_second_reset", `PFR_OFS_STATUS, 32'h5);
		summarize();
	end

endmodule
